// ===== dv/dual_port_sram_tb_top.sv
`timescale 1ns/10ps
module dual_port_sram_tb_top;
    import dpram_pkg::*;
    typedef struct {int due; logic [17:0] d; logic [17:0] m;} note_t;
    logic clk = 0;
    logic rst_b = 0;
    logic [1:0] port_clk_en = 2'h3;
    logic [1:0] output_enable_n = 2'h0;
    logic [1:0] flow_or_pipeline_select = 2'h0;
    wire [1:0] asn, cen, clr, sh, sl, rw, lb, hb;
    wire [15:0] pa [2];
    wire [17:0] pd [2];
    logic [17:0] dout [2];
    logic [17:0] oe [2];
    logic [17:0] mem [int];
    note_t q [2][$];
    note_t n;
    int cyc = 0;
    int failures = 0;
    int cmp_count = 0;
    initial forever #50 clk = ~clk;
    port_host host_l (.clk(clk), .address_strobe_n(asn[0]), .count_enable_n(cen[0]), .count_clear_n(clr[0]),
        .port_select_high(sh[0]), .port_select_low_n(sl[0]), .read_write_n(rw[0]), .low_byte_select_n(lb[0]),
        .high_byte_select_n(hb[0]), .port_address(pa[0]), .port_data_in(pd[0]));
    port_host host_r (.clk(clk), .address_strobe_n(asn[1]), .count_enable_n(cen[1]), .count_clear_n(clr[1]),
        .port_select_high(sh[1]), .port_select_low_n(sl[1]), .read_write_n(rw[1]), .low_byte_select_n(lb[1]),
        .high_byte_select_n(hb[1]), .port_address(pa[1]), .port_data_in(pd[1]));
    dual_port_sram #(.DEPTH(16384), .WIDTH(18)) dual_port_sram_inst (
        .clk(clk), .rst_b(rst_b), .port_clk_en(port_clk_en), .address_strobe_n(asn), .count_enable_n(cen),
        .count_clear_n(clr), .port_select_low_n(sl), .port_select_high(sh), .read_write_n(rw),
        .low_byte_select_n(lb), .high_byte_select_n(hb), .output_enable_n(output_enable_n),
        .flow_or_pipeline_select(flow_or_pipeline_select), .port_address(pa), .port_data_in(pd),
        .port_data_out(dout), .port_data_oe_n(oe));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // monitor: each driven result takes the oldest note
    always @(negedge clk) begin
        for (int p = 0; p < 2; p++) begin
            if (oe[p] !== 18'h3ffff) begin
                if (q[p].size() == 0) chk("unexpected", 0, 1);
                else begin
                    n = q[p].pop_front();
                    chk("cycle", n.due, cyc);
                    chk("lanes", n.m, oe[p]);
                    chk("data", n.d | n.m, dout[p] | oe[p]);
                end
            end
        end
        cyc++;
        if (cyc > 3000) begin
            failures++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic op(input int p, input logic [1:0] s, input logic a_n, c_n, r_n, w, input logic [1:0] ln,
                      input logic [15:0] a, input logic [17:0] d);
        if (p == 0) host_l.op(s, a_n, c_n, r_n, w, ln, a, d);
        else host_r.op(s, a_n, c_n, r_n, w, ln, a, d);
    endtask
    task automatic wr(input int p, input logic [1:0] s, input logic [1:0] ln, input logic [15:0] a);
        logic [17:0] d;
        d = 18'($urandom);
        op(p, s, 0, 1, 1, 0, ln, a, d);
        if (s == 2'h2 && port_clk_en[p]) begin
            if (!ln[0]) mem[a[13:0]][8:0] = d[8:0];
            if (!ln[1]) mem[a[13:0]][17:9] = d[17:9];
        end
    endtask
    task automatic rd(input int p, input logic a_n, c_n, r_n, input logic [1:0] ln, input logic [15:0] a,
                      input int ea);
        note_t m;
        op(p, 2'h2, a_n, c_n, r_n, 1, ln, a, 0);
        m.m = {{9{ln[1]}}, {9{ln[0]}}};
        m.d = mem[ea];
        m.due = cyc + 1 + int'(flow_or_pipeline_select[p]);
        if (!output_enable_n[p] && ln != 2'h3) q[p].push_back(m);
    endtask
    task automatic idle(input int k);
        repeat (k) fork
            op(0, 2'h1, 1, 1, 1, 1, 2'h3, 0, 0);
            op(1, 2'h1, 1, 1, 1, 1, 2'h3, 0, 0);
        join
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h1a5323d3));
        repeat (4) @(posedge clk);
        rst_b <= 1;
        for (int i = 0; i < 4; i++) wr(0, 2'h2, 2'h0, 16'hc000 | 16'(i));
        for (int i = 0; i < 4; i++) rd(0, 0, 1, 1, 2'h0, 16'(i), i);
        rd(0, 0, 1, 1, 2'h0, 16'h2, 2);
        rd(0, 0, 0, 0, 2'h3, 16'h1, 0);
        rd(0, 1, 0, 1, 2'h0, 16'h3, 0);
        rd(0, 1, 0, 1, 2'h0, 16'h3, 1);
        rd(0, 0, 0, 1, 2'h0, 16'h3, 3);
        rd(0, 1, 1, 1, 2'h0, 16'h0, 3);
        wr(0, 2'h2, 2'h0, 16'h3fff);
        rd(0, 1, 0, 1, 2'h0, 16'h0, 16'h3fff);
        rd(0, 1, 1, 1, 2'h0, 16'h0, 0);
        idle(3);
        flow_or_pipeline_select <= 2'h3;
        idle(2);
        rd(0, 0, 1, 1, 2'h0, 16'h1, 1);
        rd(0, 1, 0, 1, 2'h0, 16'h1, 1);
        fork rd(0, 1, 1, 1, 2'h0, 16'h1, 2); rd(1, 0, 1, 1, 2'h1, 16'h2, 2); join
        idle(3);
        flow_or_pipeline_select <= 2'h0;
        wr(0, 2'h2, 2'h1, 16'h0);
        rd(0, 0, 1, 1, 2'h2, 16'h0, 0);
        rd(0, 0, 1, 1, 2'h1, 16'h0, 0);
        idle(1);
        output_enable_n <= 2'h1;
        rd(0, 0, 1, 1, 2'h0, 16'h0, 0);
        idle(2);
        output_enable_n <= 2'h0;
        wr(0, 2'h0, 2'h0, 16'h1);
        wr(0, 2'h3, 2'h0, 16'h1);
        port_clk_en <= 2'h2;
        wr(0, 2'h2, 2'h0, 16'h1);
        idle(1);
        port_clk_en <= 2'h3;
        rd(0, 0, 1, 1, 2'h0, 16'h1, 1);
        fork wr(0, 2'h2, 2'h0, 16'h6); wr(1, 2'h2, 2'h0, 16'h5); join
        fork rd(0, 0, 1, 1, 2'h0, 16'h5, 5); rd(1, 0, 1, 1, 2'h0, 16'h5, 5); join
        fork rd(0, 0, 1, 1, 2'h0, 16'h6, 6); rd(1, 0, 1, 1, 2'h0, 16'h6, 6); join
        idle(4);
        chk("pending", 0, 32'(q[0].size() + q[1].size()));
        finish_test();
    end
endmodule

// ===== dv/port_host.sv
`timescale 1ns/10ps
module port_host (
    input wire logic clk,
    output logic address_strobe_n,
    output logic count_enable_n,
    output logic count_clear_n,
    output logic port_select_high,
    output logic port_select_low_n,
    output logic read_write_n,
    output logic low_byte_select_n,
    output logic high_byte_select_n,
    output logic [15:0] port_address,
    output logic [17:0] port_data_in
);
    initial begin
        {address_strobe_n, count_enable_n, count_clear_n, read_write_n} = 4'hf;
        {port_select_high, port_select_low_n, high_byte_select_n, low_byte_select_n} = 4'h7;
        port_address = 16'h0000;
        port_data_in = 18'h00000;
    end
    // one cycle on the port; released lines carry the inverse
    task automatic op(input logic [1:0] s, input logic a_n, c_n, r_n, w, input logic [1:0] ln,
                      input logic [15:0] a, input logic [17:0] d);
        @(posedge clk);
        {port_select_high, port_select_low_n} <= s;
        address_strobe_n <= a_n;
        count_enable_n <= c_n;
        count_clear_n <= r_n;
        read_write_n <= w;
        {high_byte_select_n, low_byte_select_n} <= ln;
        port_address <= a_n ? ~a : a;
        port_data_in <= w ? ~d : d;
    endtask
endmodule

// ===== src/burst_counter.sv
`timescale 1ns/10ps
module burst_counter
    import dpram_pkg::*;
#(
    parameter int AW = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    burst_port_if.counter bus
);
    count_act_t act;

    always_comb begin
        if (!bus.count_clear_n) begin // R10 R11
            act = ACT_CLEAR;
        end else if (!bus.address_strobe_n) begin // R5 R9
            act = ACT_LOAD;
        end else if (!bus.count_enable_n) begin // R8
            act = ACT_INC;
        end else begin
            act = ACT_HOLD;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus.count_ff <= '0;
        end else begin
            case (act)
                ACT_CLEAR: bus.count_ff <= COUNT_CLEAR_VALUE[AW-1:0]; // R10
                ACT_LOAD: bus.count_ff <= bus.port_address; // R5
                ACT_INC: bus.count_ff <= AW'(bus.count_ff + 1'b1); // R8 R15
                default: bus.count_ff <= bus.count_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    clear_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
        !bus.count_clear_n |=> bus.count_ff == '0) else $error("clear did not zero counter"); // R11
    load_takes_a: assert property (@(posedge clk) disable iff (!rst_b)
        bus.count_clear_n && !bus.address_strobe_n |=> bus.count_ff == $past(bus.port_address))
        else $error("strobe did not load counter"); // R5
    inc_steps_a: assert property (@(posedge clk) disable iff (!rst_b)
        bus.count_clear_n && bus.address_strobe_n && !bus.count_enable_n
        |=> bus.count_ff == AW'($past(bus.count_ff) + 1'b1)) else $error("counter did not step"); // R8
    hold_still_a: assert property (@(posedge clk) disable iff (!rst_b)
        bus.count_clear_n && bus.address_strobe_n && bus.count_enable_n |=> $stable(bus.count_ff))
        else $error("counter moved while idle"); // R9
    wrap_cov: cover property (@(posedge clk) disable iff (!rst_b)
        bus.count_ff == '1 && bus.count_clear_n && bus.address_strobe_n && !bus.count_enable_n);
endmodule

// ===== src/burst_port_if.sv
`timescale 1ns/10ps
interface burst_port_if #(parameter int AW = 16);
    logic address_strobe_n;
    logic count_enable_n;
    logic count_clear_n;
    logic [AW-1:0] port_address;
    logic [AW-1:0] count_ff;
    modport ctrl (output address_strobe_n, output count_enable_n, output count_clear_n,
                  output port_address, input count_ff);
    modport counter (input address_strobe_n, input count_enable_n, input count_clear_n,
                     input port_address, output count_ff);
endinterface

// ===== src/dpram_pkg.sv
package dpram_pkg;
    // array organisation
    localparam int unsigned DEPTH_DEFAULT = 65536;
    localparam int unsigned WIDTH_DEFAULT = 18;
    localparam int unsigned PIN_ADDR_W = 16;
    localparam int unsigned PIN_DATA_W = 18;
    // counter value after a clear
    localparam logic [15:0] COUNT_CLEAR_VALUE = 16'h0000;
    // extra cycles of read latency in pipelined mode
    localparam int unsigned PIPE_EXTRA_CYCLES = 1;
    // one-hot counter action encoding
    typedef enum logic [3:0] {
        ACT_HOLD = 4'h1,
        ACT_LOAD = 4'h2,
        ACT_INC = 4'h4,
        ACT_CLEAR = 4'h8
    } count_act_t;
endpackage

// ===== src/dual_port_sram.sv
// Implementation choices: the one-hot counter action encoding and a per-port clock enable.
`timescale 1ns/10ps
// Behaviour
// R1: both ports reach every cell at once, even the same cell.
// R2: array is 16K, 32K or 64K deep, 16 or 18 bits wide.
// R3: burst counter works in flow-through and pipelined modes.
// R4: external address is taken only when the strobe is low.
// R5: strobe low loads the burst counter from the address inputs.
// R6: port selected only with low select low and high select high.
// R7: port runs on rising edges of its clock, free running or strobed.
// R8: count enable low increments the counter each rising edge.
// R9: count enable ignored while strobe or clear is low.
// R10: clear low sets the counter to zero.
// R11: clear wins over strobe and count enable.
// R12: read-write select low writes, high reads.
// R13: byte selects gate their lane; lane drives only with select and output enable low.
// R14: mode select low gives flow-through, high gives pipelined.
// R15: counter covers whole array and wraps to zero.
// R16: pipelined read data comes one cycle after flow-through data.
// R17: address width follows depth; unused upper address bits ignored.
module dual_port_sram
    import dpram_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEFAULT,
    parameter int WIDTH = WIDTH_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] port_clk_en,
    input wire logic [1:0] address_strobe_n,
    input wire logic [1:0] count_enable_n,
    input wire logic [1:0] count_clear_n,
    input wire logic [1:0] port_select_low_n,
    input wire logic [1:0] port_select_high,
    input wire logic [1:0] read_write_n,
    input wire logic [1:0] low_byte_select_n,
    input wire logic [1:0] high_byte_select_n,
    input wire logic [1:0] output_enable_n,
    input wire logic [1:0] flow_or_pipeline_select,
    input wire logic [PIN_ADDR_W-1:0] port_address [2],
    input wire logic [PIN_DATA_W-1:0] port_data_in [2],
    output logic [PIN_DATA_W-1:0] port_data_out [2],
    output logic [PIN_DATA_W-1:0] port_data_oe_n [2]
);
    import dpram_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int LOW_W = WIDTH / 2;

    logic [WIDTH-1:0] mem_ff [DEPTH]; // R2
    logic [AW-1:0] cnt [2];
    logic [AW-1:0] addr [2];
    logic [1:0] sel;
    logic [1:0] wr;
    logic [WIDTH-1:0] rd [2];
    logic [WIDTH-1:0] wmask [2];
    logic [WIDTH-1:0] flow_ff [2];
    logic [1:0] lane_lo_ff [2];

    function automatic logic [WIDTH-1:0] lane_mask(input logic lo_n, input logic hi_n);
        lane_mask = {{(WIDTH-LOW_W){~hi_n}}, {LOW_W{~lo_n}}};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // per-port address path and counter
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            burst_port_if #(.AW(AW)) cif ();
            logic port_rst_b;
            assign cif.address_strobe_n = address_strobe_n[p] | ~port_clk_en[p]; // R7
            assign cif.count_enable_n = count_enable_n[p] | ~port_clk_en[p]; // R7
            assign cif.count_clear_n = count_clear_n[p] | ~port_clk_en[p]; // R7
            assign cif.port_address = port_address[p][AW-1:0]; // R17
            assign port_rst_b = rst_b;
            burst_counter #(.AW(AW)) u_cnt (
                .clk(clk),
                .rst_b(port_rst_b),
                .bus(cif.counter)
            );
            assign cnt[p] = cif.count_ff;
            // strobe low uses the pins, otherwise the counter address
            assign addr[p] = !address_strobe_n[p] ? port_address[p][AW-1:0] : cnt[p]; // R4 R3
            assign sel[p] = port_clk_en[p] & ~port_select_low_n[p] & port_select_high[p]; // R6
            assign wr[p] = sel[p] & ~read_write_n[p]; // R12
            assign rd[p] = mem_ff[addr[p]]; // R1
            assign wmask[p] = lane_mask(low_byte_select_n[p], high_byte_select_n[p]); // R13
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // array writes; right port applied last on a same-cell collision
    always_ff @(posedge clk) begin
        for (int q = 0; q < 2; q++) begin
            if (wr[q]) begin // R12
                for (int b = 0; b < WIDTH; b++) begin
                    if (wmask[q][b]) begin // R13
                        mem_ff[addr[q]][b] <= port_data_in[q][b];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read registers: extra stage used in pipelined mode
    always_ff @(posedge clk) begin
        for (int q = 0; q < 2; q++) begin
            if (!rst_b) begin
                flow_ff[q] <= '0;
                lane_lo_ff[q] <= 2'h0;
            end else if (port_clk_en[q]) begin // R7
                flow_ff[q] <= rd[q]; // R16
                lane_lo_ff[q] <= (sel[q] && read_write_n[q]) ?
                    {~high_byte_select_n[q], ~low_byte_select_n[q]} : 2'h0; // R13 R16
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output pins, registered; output enable low while driving
    always_ff @(posedge clk) begin
        for (int q = 0; q < 2; q++) begin
            if (!rst_b) begin
                port_data_out[q] <= '0;
                port_data_oe_n[q] <= '1;
            end else begin
                logic [1:0] ln;
                logic [WIDTH-1:0] m;
                ln = flow_or_pipeline_select[q] ? lane_lo_ff[q] : // R14 R16
                     ((sel[q] && read_write_n[q]) ? {~high_byte_select_n[q], ~low_byte_select_n[q]} : 2'h0);
                m = output_enable_n[q] ? '0 : lane_mask(~ln[0], ~ln[1]); // R13
                port_data_out[q] <= PIN_DATA_W'(flow_or_pipeline_select[q] ? flow_ff[q] : rd[q]);
                port_data_oe_n[q] <= ~PIN_DATA_W'(m);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    oe_gated_a: assert property (@(posedge clk) disable iff (!rst_b)
        output_enable_n[0] |=> port_data_oe_n[0] == '1) else $error("lane driven with output enable high"); // R13
    write_lanes_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr[0] && !low_byte_select_n[0] && !(wr[1] && addr[1] == addr[0])
        |=> mem_ff[$past(addr[0])][LOW_W-1:0] == $past(port_data_in[0][LOW_W-1:0]))
        else $error("low lane write lost"); // R12
    flow_data_a: assert property (@(posedge clk) disable iff (!rst_b)
        port_clk_en[1] && !flow_or_pipeline_select[1] && !wr[0] && !wr[1]
        |=> port_data_out[1] == PIN_DATA_W'($past(rd[1]))) else $error("flow-through data wrong"); // R14
    pipe_late_a: assert property (@(posedge clk) disable iff (!rst_b)
        port_clk_en[0] && flow_or_pipeline_select[0] |=> port_data_out[0] == PIN_DATA_W'($past(flow_ff[0])))
        else $error("pipelined data not one stage later"); // R16
    unselect_a: assert property (@(posedge clk) disable iff (!rst_b)
        port_select_low_n[1] || !port_select_high[1] |-> !wr[1]) else $error("write while deselected"); // R6
    ext_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
        !address_strobe_n[0] |-> addr[0] == port_address[0][AW-1:0]) else $error("strobe address not used"); // R4
    both_write_c: cover property (@(posedge clk) disable iff (!rst_b) wr[0] && wr[1]);
    same_cell_c: cover property (@(posedge clk) disable iff (!rst_b) sel[0] && sel[1] && addr[0] == addr[1]);
    pipe_read_c: cover property (@(posedge clk) disable iff (!rst_b)
        sel[0] && read_write_n[0] && flow_or_pipeline_select[0] ##2 !output_enable_n[0]);
endmodule
